//--- hdl/eeba_pkg.sv
// Constants and types shared by the EEPROM byte access controller and its array
package eeba_pkg;
	// ------------------------------------------------------------
	// Widths and depth
	// ------------------------------------------------------------
	localparam int EEBA_AW = 9;
	localparam int EEBA_DW = 8;
	localparam int EEBA_RW = 3;
	localparam int EEBA_TW = 16;
	localparam int EEBA_DEPTH = 512;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [EEBA_RW-1:0] REG_ADDR_LO = 3'h0;
	localparam logic [EEBA_RW-1:0] REG_ADDR_HI = 3'h1;
	localparam logic [EEBA_RW-1:0] REG_DATA = 3'h2;
	localparam logic [EEBA_RW-1:0] REG_CTRL = 3'h3;
	localparam logic [EEBA_RW-1:0] REG_STAT = 3'h4;
	localparam logic [EEBA_RW-1:0] REG_MASK = 3'h5;

	// ------------------------------------------------------------
	// Control and status fields
	// ------------------------------------------------------------
	localparam int CTRL_RE = 0;
	localparam int CTRL_PE = 1;
	localparam int CTRL_MPE = 2;
	localparam int CTRL_PM_LO = 4;
	localparam int CTRL_PM_HI = 5;
	localparam int STAT_DONE = 0;
	localparam int STAT_REFUSED = 1;
	localparam int STAT_W = 2;

	// ------------------------------------------------------------
	// Modes, codes and counts
	// ------------------------------------------------------------
	localparam logic [1:0] PM_ATOMIC = 2'h0;
	localparam logic [1:0] PM_ERASE = 2'h1;
	localparam logic [1:0] PM_WRITE = 2'h2;
	localparam logic [2:0] READ_STALL = 3'h4;
	localparam logic [2:0] PROG_STALL = 3'h2;
	localparam logic [2:0] MPE_WINDOW = 3'h4;
	localparam logic [EEBA_DW-1:0] ERASED_BYTE = 8'hFF;
	localparam logic [EEBA_TW-1:0] TICK_ONE = 16'h0001;

	typedef enum logic [1:0] {EEBA_OP_NONE, EEBA_OP_ERASE, EEBA_OP_WRITE, EEBA_OP_ATOMIC} eeba_op_t;
	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_PROG} eeba_state_t;
endpackage

//--- hdl/eeba_mem_if.sv
// Carrier between the controller and its byte array
interface eeba_mem_if;
	import eeba_pkg::*;
	logic re;
	eeba_op_t op;
	logic [EEBA_AW-1:0] addr;
	logic [EEBA_DW-1:0] wdata;
	logic [EEBA_DW-1:0] rdata;
	modport ctrl (output re, output op, output addr, output wdata, input rdata);
	modport mem (input re, input op, input addr, input wdata, output rdata);
endinterface

//--- hdl/eeba_mem.sv
// Nonvolatile byte array with registered read data
module eeba_mem
(
	input logic clk,
	input logic sys_rst,
	eeba_mem_if.mem m
);
	import eeba_pkg::*;

	logic [EEBA_DW-1:0] arr [EEBA_DEPTH];
	logic [EEBA_DW-1:0] rdata_r;

	// ------------------------------------------------------------
	// Array and read port
	// ------------------------------------------------------------
	// No reset on the array: its contents model retained storage
	always_ff @(posedge clk)
	begin
		case (m.op)
			EEBA_OP_ERASE: arr[m.addr] <= ERASED_BYTE;
			// Write without erase can only clear bits; stored value is the old byte ANDed with the data
			EEBA_OP_WRITE: arr[m.addr] <= arr[m.addr] & m.wdata;
			EEBA_OP_ATOMIC: arr[m.addr] <= m.wdata;
			default: ;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			rdata_r <= '0;
		else if (m.re)
			rdata_r <= arr[m.addr];
	end

	assign m.rdata = rdata_r;
endmodule

//--- hdl/eeba_ctrl.sv
// EEPROM byte access controller: registers, programming sequencer and CPU stall
//
// Contract
// - Read access stalls CPU four cycles
// - Program start stalls CPU two cycles
// - Mode zero gives erase plus write
// - Mode one gives erase only
// - Mode two gives write only
// - Program bit reads one until done
// - No new operation while programming
// - Write without erase leaves undefined byte; the array stores the old byte ANDed with the data
// - Programming time counts oscillator ticks
// - All registers reachable over register port
module eeba_ctrl
#(
	parameter logic [eeba_pkg::EEBA_TW-1:0] ATOMIC_TICKS = 16'h0022,
	parameter logic [eeba_pkg::EEBA_TW-1:0] ERASE_TICKS = 16'h0012,
	parameter logic [eeba_pkg::EEBA_TW-1:0] WRITE_TICKS = 16'h0012
)
(
	input logic clk,
	input logic sys_rst,
	input logic [eeba_pkg::EEBA_RW-1:0] reg_addr,
	input logic [eeba_pkg::EEBA_DW-1:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	output logic [eeba_pkg::EEBA_DW-1:0] reg_rdata,
	input logic osc_tick,
	output logic cpu_stall,
	output logic nv_busy,
	output logic irq
);
	import eeba_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		eeba_state_t state;
		logic [EEBA_AW-1:0] addr;
		logic [EEBA_DW-1:0] data;
		logic [1:0] mode;
		logic [2:0] win;
		logic [2:0] stall_cnt;
		logic stall;
		logic prog_on;
		eeba_op_t op;
		logic [EEBA_AW-1:0] op_addr;
		logic [EEBA_DW-1:0] op_data;
		logic [EEBA_TW-1:0] ticks;
		logic [STAT_W-1:0] stat;
		logic [STAT_W-1:0] mask;
		logic irq;
		logic [EEBA_DW-1:0] rdata;
		logic osc_s1;
		logic osc_s2;
		logic osc_s3;
		logic mem_re;
		eeba_op_t mem_op;
	} eeba_st_t;

	eeba_st_t st_r;
	eeba_st_t st_nxt;
	logic rd_go;
	logic pg_go;
	logic osc_edge;
	logic busy;
	logic ctrl_wr;

	eeba_mem_if mif ();

	eeba_mem u_mem
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.m(mif)
	);

	assign mif.re = st_r.mem_re;
	assign mif.op = st_r.mem_op;
	assign mif.addr = st_r.op_addr;
	assign mif.wdata = st_r.op_data;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.mem_re = 1'b0;
		st_nxt.mem_op = EEBA_OP_NONE;
		busy = (st_r.state != ST_IDLE);
		ctrl_wr = reg_wr && (reg_addr == REG_CTRL);
		// The second and third synchroniser stages feed the edge detector
		st_nxt.osc_s1 = osc_tick;
		st_nxt.osc_s2 = st_r.osc_s1;
		st_nxt.osc_s3 = st_r.osc_s2;
		osc_edge = st_r.osc_s2 && !st_r.osc_s3;
		// A program write only counts inside the window opened by an earlier master write
		pg_go = ctrl_wr && reg_wdata[CTRL_PE] && (st_r.win != 3'h0) && !busy;
		rd_go = ctrl_wr && reg_wdata[CTRL_RE] && !busy && !pg_go;

		if (st_r.win != 3'h0)
			st_nxt.win = st_r.win - 3'h1;

		if (reg_wr)
		begin
			case (reg_addr)
				REG_ADDR_LO: st_nxt.addr[EEBA_DW-1:0] = reg_wdata;
				REG_ADDR_HI: st_nxt.addr[EEBA_AW-1] = reg_wdata[0];
				REG_DATA: st_nxt.data = reg_wdata;
				REG_CTRL:
				begin
					// Mode is frozen while an operation runs
					if (!busy)
						st_nxt.mode = reg_wdata[CTRL_PM_HI:CTRL_PM_LO];
					if (reg_wdata[CTRL_MPE])
						st_nxt.win = MPE_WINDOW;
				end
				REG_STAT: st_nxt.stat = st_r.stat & ~reg_wdata[STAT_W-1:0];
				REG_MASK: st_nxt.mask = reg_wdata[STAT_W-1:0];
				default: ;
			endcase
		end

		// Attempts while busy are dropped and flagged; set wins over clear
		if (ctrl_wr && busy && (reg_wdata[CTRL_RE] || reg_wdata[CTRL_PE]))
			st_nxt.stat[STAT_REFUSED] = 1'b1;

		case (st_r.state)
			ST_IDLE:
			begin
				if (pg_go)
				begin
					st_nxt.state = ST_PROG;
					st_nxt.win = 3'h0;
					// Address and data are captured so later writes cannot corrupt the op
					st_nxt.op_addr = st_r.addr;
					st_nxt.op_data = st_r.data;
					case (st_r.mode)
						PM_ERASE:
						begin
							st_nxt.op = EEBA_OP_ERASE;
							st_nxt.ticks = ERASE_TICKS;
						end
						PM_WRITE:
						begin
							st_nxt.op = EEBA_OP_WRITE;
							st_nxt.ticks = WRITE_TICKS;
						end
						default:
						begin
							st_nxt.op = EEBA_OP_ATOMIC;
							st_nxt.ticks = ATOMIC_TICKS;
						end
					endcase
				end
				else if (rd_go)
				begin
					st_nxt.state = ST_READ;
					st_nxt.mem_re = 1'b1;
					st_nxt.op_addr = st_r.addr;
				end
			end
			ST_READ:
			begin
				if (!st_r.mem_re)
				begin
					st_nxt.data = mif.rdata;
					st_nxt.state = ST_IDLE;
				end
			end
			ST_PROG:
			begin
				// Duration counts oscillator edges, not system clocks
				if (osc_edge)
				begin
					if (st_r.ticks <= TICK_ONE)
					begin
						st_nxt.ticks = '0;
						st_nxt.mem_op = st_r.op;
						st_nxt.state = ST_IDLE;
						st_nxt.stat[STAT_DONE] = 1'b1;
					end
					else
						st_nxt.ticks = st_r.ticks - TICK_ONE;
				end
			end
			default: st_nxt.state = ST_IDLE;
		endcase
		// Busy pin comes from its own flop rather than a state decode
		st_nxt.prog_on = (st_nxt.state == ST_PROG);

		if (pg_go)
			st_nxt.stall_cnt = PROG_STALL;
		else if (rd_go)
			st_nxt.stall_cnt = READ_STALL;
		else if (st_r.stall_cnt != 3'h0)
			st_nxt.stall_cnt = st_r.stall_cnt - 3'h1;
		st_nxt.stall = (st_nxt.stall_cnt != 3'h0);

		st_nxt.irq = |(st_nxt.stat & st_nxt.mask);

		// Read data stand in the cycle after the strobe only
		st_nxt.rdata = '0;
		if (reg_rd)
		begin
			case (reg_addr)
				REG_ADDR_LO: st_nxt.rdata = st_r.addr[EEBA_DW-1:0];
				REG_ADDR_HI: st_nxt.rdata = {7'h00, st_r.addr[EEBA_AW-1]};
				REG_DATA: st_nxt.rdata = st_r.data;
				REG_CTRL:
				begin
					st_nxt.rdata[CTRL_PM_HI:CTRL_PM_LO] = st_r.mode;
					st_nxt.rdata[CTRL_MPE] = (st_r.win != 3'h0);
					st_nxt.rdata[CTRL_PE] = (st_r.state == ST_PROG);
					st_nxt.rdata[CTRL_RE] = (st_r.state == ST_READ);
				end
				REG_STAT: st_nxt.rdata[STAT_W-1:0] = st_r.stat;
				REG_MASK: st_nxt.rdata[STAT_W-1:0] = st_r.mask;
				default: st_nxt.rdata = '0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st_r <= '0;
			st_r.state <= ST_IDLE;
			st_r.op <= EEBA_OP_NONE;
			st_r.mem_op <= EEBA_OP_NONE;
		end
		else
			st_r <= st_nxt;
	end

	assign reg_rdata = st_r.rdata;
	assign cpu_stall = st_r.stall;
	assign nv_busy = st_r.prog_on;
	assign irq = st_r.irq;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Stall lengths hold only while no new trigger lands inside a running stall
	a_read_stall_len: assert property (rd_go |=> cpu_stall [*4] ##1 !cpu_stall)
		else $error("read stall is not four cycles");
	a_prog_stall_len: assert property (pg_go |=> cpu_stall [*2] ##1 !cpu_stall)
		else $error("program stall is not two cycles");
	a_mode_atomic: assert property (pg_go && (st_r.mode == PM_ATOMIC)
		|=> st_r.op == EEBA_OP_ATOMIC && nv_busy)
		else $error("mode zero did not start erase and write");
	a_mode_erase: assert property (pg_go && (st_r.mode == PM_ERASE)
		|=> st_r.op == EEBA_OP_ERASE && nv_busy)
		else $error("mode one did not start erase only");
	a_mode_write: assert property (pg_go && (st_r.mode == PM_WRITE)
		|=> st_r.op == EEBA_OP_WRITE && nv_busy)
		else $error("mode two did not start write only");
	a_busy_readback: assert property (reg_rd && (reg_addr == REG_CTRL) && nv_busy
		|=> reg_rdata[CTRL_PE])
		else $error("program bit read low while busy");
	a_busy_commit: assert property ($fell(nv_busy)
		|-> mif.op == st_r.op && st_r.stat[STAT_DONE])
		else $error("busy ended without committing the operation");
	a_no_restart: assert property (busy && ctrl_wr
		&& (reg_wdata[CTRL_RE] || reg_wdata[CTRL_PE])
		|=> st_r.stat[STAT_REFUSED] && $stable(st_r.op) && $stable(st_r.op_addr))
		else $error("operation started while busy");
	a_osc_timing: assert property (nv_busy && !osc_edge
		|=> $stable(st_r.ticks) || !nv_busy)
		else $error("program timer moved without an oscillator edge");
	a_mpe_window: assert property (ctrl_wr && reg_wdata[CTRL_MPE] && !pg_go
		##1 !ctrl_wr [*4] |=> st_r.win == 3'h0)
		else $error("master window did not close after four cycles");
	a_pe_in_window: assert property (ctrl_wr && reg_wdata[CTRL_PE]
		&& (st_r.win == 3'h0) && !busy |=> !nv_busy)
		else $error("program started outside master window");
	a_irq_level: assert property (irq == |(st_r.stat & st_r.mask))
		else $error("interrupt level disagrees with masked status");
	a_read_fetch: assert property (rd_go |-> ##3 st_r.data == $past(mif.rdata))
		else $error("read byte did not reach the data register");
	a_refused_sticky: assert property (st_r.stat[STAT_REFUSED] && !(reg_wr
		&& (reg_addr == REG_STAT) && reg_wdata[STAT_REFUSED]) |=> st_r.stat[STAT_REFUSED])
		else $error("refused flag cleared without a write of one");
	a_done_sticky: assert property (st_r.stat[STAT_DONE] && !(reg_wr
		&& (reg_addr == REG_STAT) && reg_wdata[STAT_DONE]) |=> st_r.stat[STAT_DONE])
		else $error("done flag cleared without a write of one");
	a_window_open: assert property (ctrl_wr && reg_wdata[CTRL_MPE] && !pg_go
		|=> st_r.win == MPE_WINDOW)
		else $error("master write did not open the window");
	a_mode_frozen: assert property (busy |=> $stable(st_r.mode))
		else $error("mode changed while an operation ran");
endmodule

//--- test/eeba_osc_model.sv
// Free-running calibrated oscillator feeding the programming timer
module eeba_osc_model
#(
	parameter int HALF_NS = 510
)
(
	output logic osc_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Oscillator
	// ----
	// Period is no multiple of the bus clock, so the synchroniser sees five different phases
	initial
	begin
		osc_tick = 1'b0;
		forever #(HALF_NS) osc_tick = ~osc_tick;
	end
endmodule

//--- test/tb_eeprom_byte_access_control.sv
// Self-checking bench for the EEPROM byte access controller
`define CHK(got, exp) \
	begin \
		checked++; \
		if ((got) !== (exp)) \
		begin \
			failures++; \
			$display("unexpected at %0t: got %h want %h", $time, got, exp); \
		end \
	end
module tb_eeprom_byte_access_control;
	timeunit 1ns;
	timeprecision 1ns;
	import eeba_pkg::*;
	logic clk;
	logic sys_rst;
	logic [EEBA_RW-1:0] reg_addr;
	logic [EEBA_DW-1:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [EEBA_DW-1:0] reg_rdata;
	logic osc_tick;
	logic cpu_stall;
	logic nv_busy;
	logic irq;
	logic [EEBA_DW-1:0] rv;
	int n;
	int failures;
	int checked;

	// ----
	// Harness
	// ----
	// Short tick counts keep each programming run under a hundred clocks
	eeba_ctrl #(.ATOMIC_TICKS(16'h0004), .ERASE_TICKS(16'h0002), .WRITE_TICKS(16'h0002)) dut
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.osc_tick(osc_tick),
		.cpu_stall(cpu_stall),
		.nv_busy(nv_busy),
		.irq(irq)
	);
	eeba_osc_model #(.HALF_NS(510)) osc
	(
		.osc_tick(osc_tick)
	);
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ----
	// Bus tasks
	// ----
	task automatic results();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wr(input logic [EEBA_RW-1:0] a, input logic [EEBA_DW-1:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [EEBA_RW-1:0] a);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
		@(posedge clk);
	endtask
	// Control write that also counts the stall cycles that follow it
	task automatic trig(input logic [EEBA_DW-1:0] d);
		reg_wr <= 1'b1;
		reg_addr <= REG_CTRL;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		n = 0;
		// Sampling starts in the cycle right after the taking edge
		for (int k = 0; k < 8; k++)
		begin
			#1 n += (cpu_stall === 1'b1) ? 1 : 0;
			@(posedge clk);
		end
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		while (nv_busy !== 1'b0 && k < 400)
		begin
			@(posedge clk);
			#1 k++;
		end
		if (nv_busy !== 1'b0)
		begin
			failures++;
			results();
		end
		@(posedge clk);
	endtask
	task automatic prog(input logic [1:0] m, input logic [EEBA_DW-1:0] d,
		input logic [EEBA_DW-1:0] e, input logic ie);
		wr(REG_DATA, d);
		wr(REG_CTRL, {2'h0, m, 4'h4});
		trig({2'h0, m, 4'h2});
		`CHK(n, 2)
		`CHK(nv_busy, 1'b1)
		wait_idle();
		rd(REG_STAT);
		`CHK(rv[STAT_DONE], 1'b1)
		`CHK(irq, ie)
		wr(REG_STAT, 8'h03);
		trig(8'h01);
		`CHK(n, 4)
		rd(REG_DATA);
		`CHK(rv, e)
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_regs();
		rd(REG_CTRL);
		`CHK(rv, 8'h00)
		wr(REG_ADDR_HI, 8'hFF);
		rd(REG_ADDR_HI);
		`CHK(rv, 8'h01)
		wr(3'h6, 8'hFF);
		rd(3'h6);
		`CHK(rv, 8'h00)
		wr(REG_ADDR_LO, 8'hA5);
		rd(REG_ADDR_LO);
		`CHK(rv, 8'hA5)
		$display("test registers done");
	endtask
	task automatic t_modes();
		wr(REG_MASK, 8'h01);
		prog(PM_ATOMIC, 8'h3C, 8'h3C, 1'b1);
		wr(REG_MASK, 8'h00);
		prog(PM_ERASE, 8'h00, 8'hFF, 1'b0);
		wr(REG_MASK, 8'h01);
		prog(PM_WRITE, 8'h5A, 8'h5A, 1'b1);
		prog(2'h3, 8'h77, 8'h77, 1'b1);
		wr(REG_DATA, 8'h11);
		wr(REG_CTRL, 8'h04);
		trig(8'h02);
		`CHK(n, 2)
		wait_idle();
		$display("test modes done");
	endtask
	task automatic t_busy();
		wr(REG_MASK, 8'h02);
		wr(REG_CTRL, 8'h04);
		wr(REG_CTRL, 8'h02);
		rd(REG_CTRL);
		`CHK(rv[CTRL_PE], 1'b1)
		wr(REG_CTRL, 8'h21);
		rd(REG_STAT);
		`CHK(rv[STAT_REFUSED], 1'b1)
		`CHK(irq, 1'b1)
		wait_idle();
		rd(REG_CTRL);
		`CHK(rv[CTRL_PE], 1'b0)
		`CHK(rv[CTRL_PM_HI:CTRL_PM_LO], PM_ATOMIC)
		wr(REG_STAT, 8'h03);
		`CHK(irq, 1'b0)
		$display("test busy done");
	endtask
	task automatic t_window();
		// Program write taken in the last open cycle of the window
		wr(REG_CTRL, 8'h04);
		repeat (2) @(posedge clk);
		trig(8'h02);
		`CHK(n, 2)
		wait_idle();
		wr(REG_CTRL, 8'h04);
		rd(REG_CTRL);
		`CHK(rv[CTRL_MPE], 1'b1)
		// Program write taken one cycle after the window closed
		@(posedge clk);
		trig(8'h02);
		`CHK(n, 0)
		`CHK(nv_busy, 1'b0)
		rd(REG_CTRL);
		`CHK(rv[CTRL_MPE], 1'b0)
		$display("test window done");
	endtask

	initial
	begin
		failures = 0;
		checked = 0;
		sys_rst = 1'b1;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_modes();
		t_busy();
		t_window();
		results();
	end
endmodule
